// >>> verilog/psr_pkg.sv
// Package for the protection status register group: addresses, bit positions, reset values.
// Assumes the serial link logic presents decoded 8-bit register addresses and 16-bit words.
package psr_pkg;

    // Register addresses as seen on the register port
    localparam logic [7:0] PSR_ADDR_AUX_STATUS = 8'h1f;
    localparam logic [7:0] PSR_ADDR_ANALOG_CTL = 8'h20;
    localparam logic [7:0] PSR_ADDR_PROT_STATUS = 8'h21;

    localparam int PSR_DATA_W = 16;
    localparam int PSR_ADDR_W = 8;

    // Auxiliary measurement enable status fields
    localparam int PSR_AUX_THERM_LSB = 8;
    localparam int PSR_AUX_THERM_MSB = 12;
    localparam int PSR_AUX_AIN2 = 7;
    localparam int PSR_AUX_AIN1 = 6;
    localparam int PSR_AUX_PACK = 5;
    localparam int PSR_AUX_CORE = 4;
    localparam int PSR_AUX_EXTREG = 3;
    localparam int PSR_AUX_MID = 2;
    localparam int PSR_AUX_VREF2 = 0;
    localparam int PSR_THERM_N = 5;

    // Analog control fields
    localparam int PSR_CTL_FIXED = 15;
    localparam int PSR_CTL_LOAD_EN = 3;
    localparam int PSR_CTL_HIGH_MASK = 2;
    localparam int PSR_CTL_LOW_MASK = 1;
    localparam int PSR_CTL_STRENGTH = 0;
    localparam int PSR_CTL_STORE_W = 15;
    localparam logic [14:0] PSR_CTL_RESET = 15'h0006;
    localparam logic PSR_CTL_FIXED_VAL = 1'h1;

    // Protection status fields
    localparam int PSR_ST_SHORT_L = 15;
    localparam int PSR_ST_DOC_L = 14;
    localparam int PSR_ST_COC_L = 13;
    localparam int PSR_ST_CRC_L = 12;
    localparam int PSR_ST_SEQ_F = 10;
    localparam int PSR_ST_SHORT = 7;
    localparam int PSR_ST_DOC = 6;
    localparam int PSR_ST_COC = 5;
    localparam int PSR_ST_TSD = 4;
    localparam int PSR_ST_CFET_ON = 3;
    localparam int PSR_ST_CFET_OFF = 2;
    localparam int PSR_ST_DFET_ON = 1;
    localparam int PSR_ST_DFET_OFF = 0;
    localparam int PSR_FET_N = 4;

    // Index of each asynchronous analog condition in the synchroniser bank
    localparam int PSR_SYN_SHORT = 0;
    localparam int PSR_SYN_DOC = 1;
    localparam int PSR_SYN_COC = 2;
    localparam int PSR_SYN_TSD = 3;
    localparam int PSR_SYN_EXT_HIGH = 4;
    localparam int PSR_SYN_EXT_LOW = 5;
    localparam int PSR_SYN_N = 6;

endpackage

// >>> verilog/psr_sync.sv
// Three-stage synchroniser bank for asynchronous analog condition levels.
// Assumes inputs are slow levels; a change is accepted once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module psr_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] level_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            logic out_d;

            always_comb begin
                out_d = out_q;
                if (s2_q == s3_q) begin
                    out_d = s3_q;
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'h0;
                    s2_q <= 1'h0;
                    s3_q <= 1'h0;
                    out_q <= 1'h0;
                end else begin
                    s1_q <= raw_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    out_q <= out_d;
                end
            end

            assign level_out[gi] = out_q;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> verilog/psr_top.sv
// Protection and measurement status register group of the battery monitor.
// Assumes the serial link logic drives the register port on ref_clk; analog conditions are async.
`timescale 1ns/10ps
`default_nettype none

module psr_top
    import psr_pkg::*;
#(
    parameter bit OC_ON_SECOND_PIN = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port from the serial link logic
    input wire logic [PSR_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [PSR_DATA_W-1:0] reg_wdata,
    output logic [PSR_DATA_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    // Measurement enables from the sequencer
    input wire logic [PSR_THERM_N-1:0] thermistor_meas_on,
    input wire logic analog_input2_meas_on,
    input wire logic analog_input1_meas_on,
    input wire logic pack_voltage_meas_on,
    input wire logic core_rail_meas_on,
    input wire logic ext_regulator_meas_on,
    input wire logic mid_rail_meas_on,
    input wire logic second_reference_meas_on,
    // Asynchronous analog conditions
    input wire logic short_detect,
    input wire logic discharge_oc_detect,
    input wire logic charge_oc_detect,
    input wire logic thermal_detect,
    input wire logic ext_reg_high_detect,
    input wire logic ext_reg_low_detect,
    // Same-clock diagnostic and link events
    input wire logic crc_error_pulse,
    input wire logic sequencer_counter_fault,
    input wire logic fet_diag_enable,
    input wire logic charge_switch_on_check,
    input wire logic charge_switch_off_check,
    input wire logic discharge_switch_on_check,
    input wire logic discharge_switch_off_check,
    // Control outputs
    output logic load_drive_enable,
    output logic load_drive_strength,
    output logic shutdown_request,
    // Alarm pins, active low
    output logic first_alarm_pin_n,
    output logic second_alarm_pin_n
);

    logic [PSR_SYN_N-1:0] live;
    logic [PSR_CTL_STORE_W-1:0] ctl_q;
    logic [PSR_CTL_STORE_W-1:0] ctl_d;
    logic short_q, short_d;
    logic doc_q, doc_d;
    logic coc_q, coc_d;
    logic crc_q, crc_d;
    logic [PSR_DATA_W-1:0] rdata_q, rdata_d;
    logic rd_valid_q;
    logic shutdown_q, shutdown_d;
    logic first_alarm_pin_n_q, first_alarm_pin_n_d;
    logic second_alarm_pin_n_q, second_alarm_pin_n_d;
    logic [PSR_DATA_W-1:0] aux_word;
    logic [PSR_DATA_W-1:0] ctl_word;
    logic [PSR_DATA_W-1:0] st_word;
    logic wr_ctl;
    logic wr_st;
    logic any_oc;

    psr_sync #(
        .WIDTH(PSR_SYN_N)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw_in({ext_reg_low_detect, ext_reg_high_detect, thermal_detect,
                 charge_oc_detect, discharge_oc_detect, short_detect}),
        .level_out(live)
    );

    assign wr_ctl = reg_wr && (reg_addr == PSR_ADDR_ANALOG_CTL);
    assign wr_st = reg_wr && (reg_addr == PSR_ADDR_PROT_STATUS);

    // Read words
    always_comb begin
        aux_word = '0;
        aux_word[PSR_AUX_THERM_MSB:PSR_AUX_THERM_LSB] = thermistor_meas_on;
        aux_word[PSR_AUX_AIN2] = analog_input2_meas_on;
        aux_word[PSR_AUX_AIN1] = analog_input1_meas_on;
        aux_word[PSR_AUX_PACK] = pack_voltage_meas_on;
        aux_word[PSR_AUX_CORE] = core_rail_meas_on;
        aux_word[PSR_AUX_EXTREG] = ext_regulator_meas_on;
        aux_word[PSR_AUX_MID] = mid_rail_meas_on;
        aux_word[PSR_AUX_VREF2] = second_reference_meas_on;

        ctl_word = {PSR_CTL_FIXED_VAL, ctl_q};

        st_word = '0;
        st_word[PSR_ST_SHORT_L] = short_q;
        st_word[PSR_ST_DOC_L] = doc_q;
        st_word[PSR_ST_COC_L] = coc_q;
        st_word[PSR_ST_CRC_L] = crc_q;
        st_word[PSR_ST_SEQ_F] = sequencer_counter_fault;
        st_word[PSR_ST_SHORT] = live[PSR_SYN_SHORT];
        st_word[PSR_ST_DOC] = live[PSR_SYN_DOC];
        st_word[PSR_ST_COC] = live[PSR_SYN_COC];
        st_word[PSR_ST_TSD] = live[PSR_SYN_TSD];
        // FET checks gated by diagnostic enable
        st_word[PSR_ST_CFET_ON] = fet_diag_enable && charge_switch_on_check;
        st_word[PSR_ST_CFET_OFF] = fet_diag_enable && charge_switch_off_check;
        st_word[PSR_ST_DFET_ON] = fet_diag_enable && discharge_switch_on_check;
        st_word[PSR_ST_DFET_OFF] = fet_diag_enable && discharge_switch_off_check;
    end

    // Register next values
    always_comb begin
        ctl_d = ctl_q;
        // user storage and control bits written together
        if (wr_ctl) begin
            ctl_d = reg_wdata[PSR_CTL_STORE_W-1:0];
        end

        // short latch, set wins over clear
        short_d = live[PSR_SYN_SHORT] ||
                  (short_q && !(wr_st && reg_wdata[PSR_ST_SHORT_L]));
        doc_d = live[PSR_SYN_DOC] ||
                (doc_q && !(wr_st && reg_wdata[PSR_ST_DOC_L]));
        coc_d = live[PSR_SYN_COC] ||
                (coc_q && !(wr_st && reg_wdata[PSR_ST_COC_L]));
        crc_d = crc_error_pulse ||
                (crc_q && !(wr_st && reg_wdata[PSR_ST_CRC_L]));

        shutdown_d = (live[PSR_SYN_EXT_HIGH] && !ctl_q[PSR_CTL_HIGH_MASK]) ||
                     (live[PSR_SYN_EXT_LOW] && !ctl_q[PSR_CTL_LOW_MASK]);

        any_oc = doc_d || coc_d;
        first_alarm_pin_n_d = !(short_d || (any_oc && !OC_ON_SECOND_PIN));
        second_alarm_pin_n_d = !(any_oc && OC_ON_SECOND_PIN);

        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                PSR_ADDR_AUX_STATUS: rdata_d = aux_word;
                PSR_ADDR_ANALOG_CTL: rdata_d = ctl_word;
                PSR_ADDR_PROT_STATUS: rdata_d = st_word;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= PSR_CTL_RESET;
            short_q <= 1'h0;
            doc_q <= 1'h0;
            coc_q <= 1'h0;
            crc_q <= 1'h0;
            shutdown_q <= 1'h0;
            first_alarm_pin_n_q <= 1'h1;
            second_alarm_pin_n_q <= 1'h1;
            rdata_q <= '0;
            rd_valid_q <= 1'h0;
        end else begin
            ctl_q <= ctl_d;
            short_q <= short_d;
            doc_q <= doc_d;
            coc_q <= coc_d;
            crc_q <= crc_d;
            shutdown_q <= shutdown_d;
            first_alarm_pin_n_q <= first_alarm_pin_n_d;
            second_alarm_pin_n_q <= second_alarm_pin_n_d;
            rdata_q <= rdata_d;
            rd_valid_q <= reg_rd;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign load_drive_enable = ctl_q[PSR_CTL_LOAD_EN];
    assign load_drive_strength = ctl_q[PSR_CTL_STRENGTH];
    assign shutdown_request = shutdown_q;
    assign first_alarm_pin_n = first_alarm_pin_n_q;
    assign second_alarm_pin_n = second_alarm_pin_n_q;

    // Checks
    sequence s_clear_short;
        wr_st && reg_wdata[PSR_ST_SHORT_L] && !live[PSR_SYN_SHORT];
    endsequence

    sequence s_read_ctl;
        reg_rd && (reg_addr == PSR_ADDR_ANALOG_CTL);
    endsequence

    chk_short_alarm_pin: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        short_q |-> !first_alarm_pin_n)
        else $error("short latch set but first alarm pin high");

    chk_short_clear_w1c: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_clear_short |=> !short_q)
        else $error("short latch not cleared by write one");

    chk_set_wins_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_st && live[PSR_SYN_SHORT]) |=> short_q)
        else $error("short event lost on clear");

    chk_zero_write_keeps: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_st && doc_q && !reg_wdata[PSR_ST_DOC_L]) |=> doc_q)
        else $error("discharge latch cleared by zero write");

    chk_oc_drives_pin: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (doc_q || coc_q) |-> (!first_alarm_pin_n || !second_alarm_pin_n))
        else $error("overcurrent latch without alarm pin low");

    chk_crc_latch_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        crc_error_pulse |=> crc_q)
        else $error("crc error not latched");

    chk_ctl_fixed_one: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_read_ctl |=> (reg_rd_valid && reg_rdata[PSR_CTL_FIXED]))
        else $error("control bit 15 not reading one");

    chk_load_enable_wr: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_ctl |=> (load_drive_enable == $past(reg_wdata[PSR_CTL_LOAD_EN])))
        else $error("load drive enable not written");

    chk_high_shutdown: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (live[PSR_SYN_EXT_HIGH] && !ctl_q[PSR_CTL_HIGH_MASK]) |=> shutdown_request)
        else $error("regulator high fault did not shut down");

    chk_thermistor_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == PSR_ADDR_AUX_STATUS) |=>
        (reg_rdata[PSR_AUX_THERM_MSB:PSR_AUX_THERM_LSB] == $past(thermistor_meas_on)))
        else $error("thermistor enables misread");

    chk_fet_diag_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == PSR_ADDR_PROT_STATUS && !fet_diag_enable) |=>
        (reg_rdata[PSR_FET_N-1:0] == '0))
        else $error("fet checks nonzero while diagnostics off");

    chk_low_shutdown: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (live[PSR_SYN_EXT_LOW] && !ctl_q[PSR_CTL_LOW_MASK]) |=> shutdown_request)
        else $error("regulator low fault did not shut down");

    chk_masked_no_shutdown: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ((!live[PSR_SYN_EXT_HIGH] || ctl_q[PSR_CTL_HIGH_MASK]) &&
         (!live[PSR_SYN_EXT_LOW] || ctl_q[PSR_CTL_LOW_MASK])) |=> !shutdown_request)
        else $error("masked regulator fault caused shutdown");

    chk_live_short_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == PSR_ADDR_PROT_STATUS) |=>
        (reg_rdata[PSR_ST_SHORT] == $past(live[PSR_SYN_SHORT])))
        else $error("live short flag misread");

endmodule

`default_nettype wire

// >>> tb/psr_host_model.sv
// Host register master model for the protection status register group.
// Assumes the register port samples strobes on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none

module psr_host_model
    import psr_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [PSR_ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [PSR_DATA_W-1:0] reg_wdata,
    input wire logic [PSR_DATA_W-1:0] reg_rdata,
    input wire logic reg_rd_valid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 16'h0000;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_wdata = (addr == PSR_ADDR_ANALOG_CTL) ? (data & 16'hff8f) :
            (addr == PSR_ADDR_PROT_STATUS) ? (data & 16'hf7ff) : data;
        reg_wr = 1'h1;
        @(negedge ref_clk);
        reg_wr = 1'h0;
        // Released data no longer shows the last value
        reg_wdata = ~reg_wdata;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_rd = 1'h1;
        @(negedge ref_clk);
        reg_rd = 1'h0;
        data = 16'hxxxx;
        if (reg_rd_valid === 1'h1) begin
            data = reg_rdata;
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the protection status register group.
// Assumes the host model owns the register port; all other inputs are driven here.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import psr_pkg::*;
();
    logic ref_clk, rst_n, reg_wr, reg_rd, reg_rd_valid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v, lat;
    logic [4:0] thermistor_meas_on;
    logic analog_input2_meas_on, analog_input1_meas_on, pack_voltage_meas_on;
    logic core_rail_meas_on, ext_regulator_meas_on, mid_rail_meas_on, second_reference_meas_on;
    logic short_detect, discharge_oc_detect, charge_oc_detect, thermal_detect;
    logic ext_reg_high_detect, ext_reg_low_detect, crc_error_pulse, sequencer_counter_fault;
    logic fet_diag_enable, charge_switch_on_check, charge_switch_off_check;
    logic discharge_switch_on_check, discharge_switch_off_check;
    logic load_drive_enable, load_drive_strength, shutdown_request;
    logic first_alarm_pin_n, second_alarm_pin_n;
    int num_errors = 0;
    int samples_checked = 0;

    psr_top #(.OC_ON_SECOND_PIN(1'h1)) i_dut (
        .ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rd_valid,
        .thermistor_meas_on, .analog_input2_meas_on, .analog_input1_meas_on,
        .pack_voltage_meas_on, .core_rail_meas_on, .ext_regulator_meas_on, .mid_rail_meas_on,
        .second_reference_meas_on, .short_detect, .discharge_oc_detect, .charge_oc_detect,
        .thermal_detect, .ext_reg_high_detect, .ext_reg_low_detect, .crc_error_pulse,
        .sequencer_counter_fault, .fet_diag_enable, .charge_switch_on_check,
        .charge_switch_off_check, .discharge_switch_on_check, .discharge_switch_off_check,
        .load_drive_enable, .load_drive_strength, .shutdown_request, .first_alarm_pin_n,
        .second_alarm_pin_n
    );

    psr_host_model i_host (
        .ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rd_valid
    );

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: word 0x%h, wanted 0x%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: output %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        i_host.read_reg(addr, d);
        check16(d, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic set_aux(input logic [15:0] val);
        @(negedge ref_clk);
        thermistor_meas_on = val[12:8];
        {analog_input2_meas_on, analog_input1_meas_on, pack_voltage_meas_on, core_rail_meas_on,
            ext_regulator_meas_on, mid_rail_meas_on} = val[7:2];
        second_reference_meas_on = val[0];
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run is about 360 cycles
    initial begin
        #30000;
        num_errors++;
        stop_test();
    end

    initial begin
        rst_n = 1'h0;
        set_aux(16'h0000);
        {short_detect, discharge_oc_detect, charge_oc_detect, thermal_detect} = 4'h0;
        {ext_reg_high_detect, ext_reg_low_detect, crc_error_pulse} = 3'h0;
        {sequencer_counter_fault, fet_diag_enable} = 2'h0;
        {charge_switch_on_check, charge_switch_off_check, discharge_switch_on_check,
            discharge_switch_off_check} = 4'h0;
        settle(1);
        rst_n = 1'h1;
        check1(first_alarm_pin_n, 1'h1);
        check1(second_alarm_pin_n, 1'h1);
        check1(load_drive_enable, 1'h0);
        check1(load_drive_strength, 1'h0);
        rd_chk(PSR_ADDR_ANALOG_CTL, 16'h8006);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h0000);
        // Walking one over every aux bit, then all ones
        for (int i = 0; i < 17; i++) begin
            v = (i == 16) ? 16'hffff : (16'h0001 << i);
            set_aux(v);
            rd_chk(PSR_ADDR_AUX_STATUS, v & 16'h1ffd);
        end
        i_host.write_reg(PSR_ADDR_AUX_STATUS, 16'h0000);
        rd_chk(PSR_ADDR_AUX_STATUS, 16'h1ffd);
        i_host.write_reg(PSR_ADDR_ANALOG_CTL, 16'hffff);
        check1(load_drive_enable, 1'h1);
        check1(load_drive_strength, 1'h1);
        rd_chk(PSR_ADDR_ANALOG_CTL, 16'hff8f);
        i_host.write_reg(PSR_ADDR_ANALOG_CTL, 16'h0000);
        check1(load_drive_enable, 1'h0);
        check1(load_drive_strength, 1'h0);
        rd_chk(PSR_ADDR_ANALOG_CTL, 16'h8000);
        // Bit 0 of i picks the low condition, bits 2..1 land on control bits 2..1
        for (int i = 0; i < 8; i++) begin
            i_host.write_reg(PSR_ADDR_ANALOG_CTL, 16'(i[2:1]) << 1);
            {ext_reg_low_detect, ext_reg_high_detect} = i[0] ? 2'h2 : 2'h1;
            settle(8);
            check1(shutdown_request, i[0] ? !i[1] : !i[2]);
            {ext_reg_low_detect, ext_reg_high_detect} = 2'h0;
            settle(8);
            check1(shutdown_request, 1'h0);
        end
        // Short, discharge and charge overcurrent in turn
        for (int k = 0; k < 3; k++) begin
            lat = 16'h8000 >> k;
            {short_detect, discharge_oc_detect, charge_oc_detect} = 3'h4 >> k;
            settle(8);
            rd_chk(PSR_ADDR_PROT_STATUS, lat | (16'h0080 >> k));
            check1(first_alarm_pin_n, k != 0);
            check1(second_alarm_pin_n, k == 0);
            // Clear while the condition still stands: the set wins
            i_host.write_reg(PSR_ADDR_PROT_STATUS, lat);
            rd_chk(PSR_ADDR_PROT_STATUS, lat | (16'h0080 >> k));
            {short_detect, discharge_oc_detect, charge_oc_detect} = 3'h0;
            settle(8);
            rd_chk(PSR_ADDR_PROT_STATUS, lat);
            i_host.write_reg(PSR_ADDR_PROT_STATUS, ~lat);
            rd_chk(PSR_ADDR_PROT_STATUS, lat);
            check1(first_alarm_pin_n, k != 0);
            i_host.write_reg(PSR_ADDR_PROT_STATUS, lat);
            rd_chk(PSR_ADDR_PROT_STATUS, 16'h0000);
            check1(first_alarm_pin_n, 1'h1);
            check1(second_alarm_pin_n, 1'h1);
        end
        crc_error_pulse = 1'h1;
        settle(1);
        crc_error_pulse = 1'h0;
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h1000);
        i_host.write_reg(PSR_ADDR_PROT_STATUS, 16'h0fff);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h1000);
        i_host.write_reg(PSR_ADDR_PROT_STATUS, 16'h1000);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h0000);
        {sequencer_counter_fault, thermal_detect} = 2'h3;
        {charge_switch_on_check, charge_switch_off_check, discharge_switch_on_check,
            discharge_switch_off_check} = 4'ha;
        settle(8);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h0410);
        fet_diag_enable = 1'h1;
        settle(1);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h041a);
        i_host.write_reg(PSR_ADDR_PROT_STATUS, 16'h0000);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h041a);
        {sequencer_counter_fault, thermal_detect} = 2'h0;
        {charge_switch_on_check, charge_switch_off_check, discharge_switch_on_check,
            discharge_switch_off_check} = 4'h5;
        settle(8);
        rd_chk(PSR_ADDR_PROT_STATUS, 16'h0005);
        // Unmapped place, then a reset in mid-run
        i_host.write_reg(8'h22, 16'hffff);
        rd_chk(8'h22, 16'h0000);
        i_host.write_reg(PSR_ADDR_ANALOG_CTL, 16'h7fff);
        check1(load_drive_enable, 1'h1);
        rst_n = 1'h0;
        settle(2);
        check1(load_drive_enable, 1'h0);
        rst_n = 1'h1;
        rd_chk(PSR_ADDR_ANALOG_CTL, 16'h8006);
        stop_test();
    end
endmodule

`default_nettype wire
